// File: logic/wma_core.sv
// execution datapath for word moves/exchange and byte add/sub/and.
// assumes the sequencer presents one instruction on start with its
// memory operand already fetched; results and flags update on the clock after start, before done.
// How it works
// - every cycle count is in periods of the selected core clock.
// - internal RAM or no data access uses the shorter count, immediate add 4.
// - operand outside internal RAM uses the longer count, short direct 5.
// - each external read wait adds one clock per byte read, 9 plus n.
// - external word store takes 12 plus twice the write waits.
// - external word load takes 12 plus twice the read waits.
// - word move and exchange take only BC, DE, HL; 4 clocks, 1 byte.
// - immediate add to short direct byte writes back sum and flags, 6 or 8.
// - add with carry adds operand and carry, updates zero, half carry, carry.
// - subtract leaves borrow in carry; the HL plus byte form uses pointer plus displacement.
// - subtract with borrow removes operand and carry, writes all three flags.
// - AND stores bitwise product, updates only zero.
// - register-indexed operands use pointer plus index, 2 bytes, 8 clocks.
// - counts assume execution from internal program ROM.
// - unaffected flags keep their value; crossed flags follow the result.
// - short direct reaches FE20 to FF1F only; pair form needs even address.
`timescale 1ns/1ps
module wma_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire wma_pkg::wma_op_t op,
	input wire wma_pkg::wma_amode_t amode,
	input wire logic [1:0] rp_sel,
	input wire logic [7:0] operand,
	input wire logic [7:0] dest_in,
	input wire logic dest_is_acc,
	input wire logic [15:0] mem_word,
	input wire logic [15:0] saddr,
	input wire logic [7:0] disp,
	input wire logic [7:0] idx_b,
	input wire logic [7:0] idx_c,
	input wire logic ext_area,
	input wire logic [3:0] read_waits,
	input wire logic [3:0] write_waits,
	output logic busy,
	output logic done,
	output logic illegal,
	output logic [7:0] result,
	output logic [15:0] word_accumulator,
	output logic [15:0] general_pair_one,
	output logic [15:0] general_pair_two,
	output logic [15:0] pointer_pair,
	output logic [15:0] eff_addr,
	output logic [15:0] store_word,
	output logic carry_flag,
	output logic half_carry_flag,
	output logic zero_flag,
	output logic [5:0] cycles_used
);
	import wma_pkg::*;
	typedef enum logic [1:0] {WMA_IDLE, WMA_RUN, WMA_DONE} wma_state_t;
	wma_state_t state_reg;
	logic [5:0] len;
	logic [5:0] base_len;
	logic [5:0] cnt_reg;
	logic [8:0] sum9;
	logic [4:0] low5;
	logic [7:0] res8;
	logic cin;
	logic is_arith;
	logic is_and;
	logic pair_ok;
	logic addr_ok;
	logic bad;
	logic [15:0] rp_val;
	logic [15:0] ea_next;

	wma_cycle_count u_len (
		.op(op),
		.amode(amode),
		.ext_area(ext_area),
		.read_waits(read_waits),
		.write_waits(write_waits),
		.cycles(base_len)
	);

	// immediate into a short direct byte: read, modify and write back costs more
	always_comb begin
		len = base_len;
		if (amode == WMA_AM_SADDR && !dest_is_acc && (is_arith || is_and))
			len = ext_area ? WMA_CYC_SADDR_IMM_SLOW : WMA_CYC_SADDR_IMM_FAST;
	end

	assign is_and = (op == WMA_OP_AND);
	assign is_arith = (op inside {WMA_OP_ADD, WMA_OP_ADD_WITH_CARRY_OP, WMA_OP_SUB, WMA_OP_SUBTRACT_WITH_BORROW_OP});
	// carry in only for the chained forms
	assign cin = (op == WMA_OP_ADD_WITH_CARRY_OP || op == WMA_OP_SUBTRACT_WITH_BORROW_OP) ? carry_flag : 1'b0;
	always_comb begin
		sum9 = 9'h000;
		low5 = 5'h00;
		unique case (op)
			WMA_OP_ADD, WMA_OP_ADD_WITH_CARRY_OP: begin
				sum9 = {1'b0, dest_in} + {1'b0, operand} + {8'h00, cin};
				low5 = {1'b0, dest_in[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
			end
			WMA_OP_SUB, WMA_OP_SUBTRACT_WITH_BORROW_OP: begin
				// bit 8 of the difference is the borrow
				sum9 = {1'b0, dest_in} - {1'b0, operand} - {8'h00, cin};
				low5 = {1'b0, dest_in[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
			end
			default: begin
				sum9 = {1'b0, dest_in & operand};
				low5 = 5'h00;
			end
		endcase
	end
	assign res8 = sum9[7:0];

	always_comb begin
		unique case (rp_sel)
			WMA_RP_BC: rp_val = general_pair_one;
			WMA_RP_DE: rp_val = general_pair_two;
			WMA_RP_HL: rp_val = pointer_pair;
			default: rp_val = word_accumulator;
		endcase
	end
	// AX itself is not a legal partner for the word moves
	assign pair_ok = (rp_sel != WMA_RP_AX);
	assign addr_ok = (saddr >= WMA_SADDR_LO) && (saddr <= WMA_SADDR_HI);
	always_comb begin
		bad = 1'b0;
		if (op inside {WMA_OP_WORD_MOVE_OP_RP_AX, WMA_OP_WORD_MOVE_OP_AX_RP, WMA_OP_WORD_SWAP_OP})
			bad = !pair_ok;
		else if (amode == WMA_AM_SADDR && !(op inside {WMA_OP_WORD_MOVE_OP_AX_MEM, WMA_OP_WORD_MOVE_OP_MEM_AX}))
			bad = !addr_ok;
		else if (op inside {WMA_OP_WORD_MOVE_OP_AX_MEM, WMA_OP_WORD_MOVE_OP_MEM_AX})
			bad = saddr[0] || (amode == WMA_AM_SADDR && !addr_ok);
	end
	always_comb begin
		unique case (amode)
			WMA_AM_HL_BYTE: ea_next = pointer_pair + {8'h00, disp};
			WMA_AM_HL_B: ea_next = pointer_pair + {8'h00, idx_b};
			WMA_AM_HL_C: ea_next = pointer_pair + {8'h00, idx_c};
			WMA_AM_HL: ea_next = pointer_pair;
			default: ea_next = saddr;
		endcase
	end

	// sequencer: count clocks of the selected core clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= WMA_IDLE;
			cnt_reg <= 6'h00;
		end else begin
			unique case (state_reg)
				WMA_IDLE: if (start) begin
					state_reg <= bad ? WMA_DONE : WMA_RUN;
					cnt_reg <= bad ? 6'h01 : len - 6'h01;
				end
				WMA_RUN: if (cnt_reg == 6'h01) state_reg <= WMA_DONE;
					else cnt_reg <= cnt_reg - 6'h01;
				WMA_DONE: state_reg <= WMA_IDLE;
			endcase
		end
	end

	// flags latched at start, visible from the next clock, before done
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			carry_flag <= 1'b0;
			half_carry_flag <= 1'b0;
			zero_flag <= 1'b0;
			result <= WMA_RESET_BYTE;
			illegal <= 1'b0;
		end else if (state_reg == WMA_IDLE && start) begin
			illegal <= bad;
			if (!bad && (is_arith || is_and)) begin
				result <= res8;
				zero_flag <= (res8 == 8'h00);
				if (is_arith) begin
					carry_flag <= sum9[8];
					half_carry_flag <= low5[4];
				end // AND leaves carry and half carry
			end
		end
	end

	// register pairs; the accumulator low byte takes byte results
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			word_accumulator <= WMA_RESET_WORD;
			general_pair_one <= WMA_RESET_WORD;
			general_pair_two <= WMA_RESET_WORD;
			pointer_pair <= WMA_RESET_WORD;
			store_word <= WMA_RESET_WORD;
			eff_addr <= WMA_RESET_WORD;
		end else if (state_reg == WMA_IDLE && start && !bad) begin
			eff_addr <= ea_next;
			unique case (op)
				WMA_OP_WORD_MOVE_OP_AX_RP: word_accumulator <= rp_val;
				WMA_OP_WORD_MOVE_OP_AX_MEM: word_accumulator <= mem_word;
				WMA_OP_WORD_MOVE_OP_MEM_AX: store_word <= word_accumulator;
				WMA_OP_WORD_MOVE_OP_RP_AX, WMA_OP_WORD_SWAP_OP: begin
					if (op == WMA_OP_WORD_SWAP_OP) word_accumulator <= rp_val;
					unique case (rp_sel)
						WMA_RP_BC: general_pair_one <= word_accumulator;
						WMA_RP_DE: general_pair_two <= word_accumulator;
						default: pointer_pair <= word_accumulator;
					endcase
				end
				default: if (dest_is_acc) word_accumulator[7:0] <= res8;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			cycles_used <= 6'h00;
		end else begin
			busy <= (state_reg == WMA_IDLE) ? start : (state_reg == WMA_RUN && cnt_reg != 6'h01);
			done <= (state_reg == WMA_RUN && cnt_reg == 6'h01);
			if (state_reg == WMA_IDLE && start) cycles_used <= bad ? 6'h01 : len;
		end
	end

	a_and_flags: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && is_and && !bad) |=>
		(carry_flag == $past(carry_flag) && half_carry_flag == $past(half_carry_flag)))
		else $error("and changed carry flags");
	a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && (is_arith || is_and) && !bad) |=>
		(zero_flag == (result == 8'h00)))
		else $error("zero flag mismatch");
	a_pair_reject: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && rp_sel == WMA_RP_AX &&
		(op inside {WMA_OP_WORD_MOVE_OP_RP_AX, WMA_OP_WORD_MOVE_OP_AX_RP, WMA_OP_WORD_SWAP_OP})) |=> illegal)
		else $error("ax accepted as partner");
	a_saddr_window: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && amode == WMA_AM_SADDR && !addr_ok) |=> illegal)
		else $error("short direct outside window");
	a_rp_length: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && op == WMA_OP_WORD_MOVE_OP_AX_RP && pair_ok) |=> ##3 done)
		else $error("word move not 4 clocks");
	a_word_load: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && op == WMA_OP_WORD_MOVE_OP_AX_MEM && ext_area && !bad) |=>
		(cycles_used == 6'h0C + {read_waits, 1'b0}))
		else $error("word load count wrong");
	a_word_store: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && op == WMA_OP_WORD_MOVE_OP_MEM_AX && ext_area && !bad) |=>
		(cycles_used == 6'h0C + {write_waits, 1'b0}))
		else $error("word store count wrong");
	a_imm_add: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && op == WMA_OP_ADD && amode == WMA_AM_IMM) |=> ##3 done)
		else $error("immediate add not 4 clocks");
	a_idx_len: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == WMA_IDLE && start && amode == WMA_AM_HL_B && is_arith) |=>
		(cycles_used == ($past(ext_area) ? 6'h09 + {2'h0, $past(read_waits)} : 6'h08)))
		else $error("indexed count wrong");
endmodule

// File: logic/wma_pkg.sv
// package for the word-move and byte-arithmetic execution datapath.
// assumes one core clock; cycle counts are in core clocks.
package wma_pkg;
	typedef enum logic [3:0] {
		WMA_OP_ADD,
		WMA_OP_ADD_WITH_CARRY_OP,
		WMA_OP_SUB,
		WMA_OP_SUBTRACT_WITH_BORROW_OP,
		WMA_OP_AND,
		WMA_OP_WORD_MOVE_OP_RP_AX,
		WMA_OP_WORD_MOVE_OP_AX_RP,
		WMA_OP_WORD_SWAP_OP,
		WMA_OP_WORD_MOVE_OP_AX_MEM,
		WMA_OP_WORD_MOVE_OP_MEM_AX
	} wma_op_t;
	typedef enum logic [2:0] {
		WMA_AM_IMM,
		WMA_AM_REG,
		WMA_AM_SADDR,
		WMA_AM_ABS,
		WMA_AM_HL,
		WMA_AM_HL_BYTE,
		WMA_AM_HL_B,
		WMA_AM_HL_C
	} wma_amode_t;
	localparam logic [1:0] WMA_RP_AX = 2'h0;
	localparam logic [1:0] WMA_RP_BC = 2'h1;
	localparam logic [1:0] WMA_RP_DE = 2'h2;
	localparam logic [1:0] WMA_RP_HL = 2'h3;
	localparam logic [15:0] WMA_SADDR_LO = 16'hFE20;
	localparam logic [15:0] WMA_SADDR_HI = 16'hFF1F;
	localparam logic [5:0] WMA_CYC_RP = 6'h04;
	localparam logic [5:0] WMA_CYC_IMM = 6'h04;
	localparam logic [5:0] WMA_CYC_SADDR_FAST = 6'h04;
	localparam logic [5:0] WMA_CYC_SADDR_SLOW = 6'h05;
	localparam logic [5:0] WMA_CYC_SADDR_IMM_FAST = 6'h06;
	localparam logic [5:0] WMA_CYC_SADDR_IMM_SLOW = 6'h08;
	localparam logic [5:0] WMA_CYC_HL_FAST = 6'h04;
	localparam logic [5:0] WMA_CYC_HL_SLOW = 6'h05;
	localparam logic [5:0] WMA_CYC_IDX_FAST = 6'h08;
	localparam logic [5:0] WMA_CYC_IDX_SLOW = 6'h09;
	localparam logic [5:0] WMA_CYC_WORD_FAST = 6'h0A;
	localparam logic [5:0] WMA_CYC_WORD_SLOW = 6'h0C;
	localparam logic [7:0] WMA_RESET_BYTE = 8'h00;
	localparam logic [15:0] WMA_RESET_WORD = 16'h0000;
endpackage

// File: logic/wma_cycle_count.sv
// instruction length calculator: base count by operand form, plus waits.
// assumes waits are already resolved by the memory side for this access.
`timescale 1ns/1ps
module wma_cycle_count (
	input wire wma_pkg::wma_op_t op,
	input wire wma_pkg::wma_amode_t amode,
	input wire logic ext_area,
	input wire logic [3:0] read_waits,
	input wire logic [3:0] write_waits,
	output logic [5:0] cycles
);
	import wma_pkg::*;
	logic [5:0] rw;
	logic [5:0] ww;
	assign rw = {2'h0, read_waits};
	assign ww = {2'h0, write_waits};
	always_comb begin
		cycles = WMA_CYC_IMM;
		unique case (op)
			WMA_OP_WORD_MOVE_OP_RP_AX, WMA_OP_WORD_MOVE_OP_AX_RP, WMA_OP_WORD_SWAP_OP: begin
				cycles = WMA_CYC_RP;
			end
			WMA_OP_WORD_MOVE_OP_AX_MEM: begin
				// two bytes read, each waits
				cycles = ext_area ? WMA_CYC_WORD_SLOW + (rw << 1) : WMA_CYC_WORD_FAST;
			end
			WMA_OP_WORD_MOVE_OP_MEM_AX: begin
				cycles = ext_area ? WMA_CYC_WORD_SLOW + (ww << 1) : WMA_CYC_WORD_FAST;
			end
			default: begin
				unique case (amode)
					WMA_AM_IMM, WMA_AM_REG: cycles = WMA_CYC_IMM;
					WMA_AM_SADDR: begin
						cycles = ext_area ? WMA_CYC_SADDR_SLOW : WMA_CYC_SADDR_FAST;
					end
					WMA_AM_HL: begin
						cycles = ext_area ? WMA_CYC_HL_SLOW + rw : WMA_CYC_HL_FAST;
					end
					WMA_AM_ABS, WMA_AM_HL_BYTE, WMA_AM_HL_B, WMA_AM_HL_C: begin
						cycles = ext_area ? WMA_CYC_IDX_SLOW + rw : WMA_CYC_IDX_FAST;
					end
				endcase
			end
		endcase
	end
endmodule

// File: test/wma_mem_model.sv
// memory side model: internal fast ram versus outer area, with wait counts.
// assumes the bench holds the operand address on addr before each start.
`timescale 1ns/1ps
module wma_mem_model #(
	parameter logic [15:0] HS_LO = 16'hFB00,
	parameter logic [15:0] HS_HI = 16'hFEFF
) (
	input wire logic [15:0] addr,
	input wire logic [3:0] n_cfg,
	input wire logic [3:0] m_cfg,
	output logic ext_area,
	output logic [3:0] read_waits,
	output logic [3:0] write_waits,
	output logic [15:0] mem_word
);
	// outside the fast window the slow count applies
	assign ext_area = (addr < HS_LO) || (addr > HS_HI);
	// fast ram never inserts waits
	assign read_waits = ext_area ? n_cfg : 4'h0;
	assign write_waits = ext_area ? m_cfg : 4'h0;
	// address-derived pattern so a stale word is visible
	assign mem_word = {addr[7:0], addr[15:8]} ^ 16'hA55A;
endmodule

// File: test/test_cpu_word_move_and_byte_arith.sv
// self-checking bench for the word-move and byte-arithmetic datapath.
// assumes wma_core and the memory model; drives inputs at falling edges.
`timescale 1ns/1ps
module test_cpu_word_move_and_byte_arith;
	import wma_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	logic dest_is_acc = 1'b1;
	wma_op_t op = WMA_OP_ADD;
	wma_amode_t amode = WMA_AM_IMM;
	logic [1:0] rp_sel = WMA_RP_BC;
	logic [7:0] operand = 8'h00, dest_in = 8'h00, disp = 8'h00, idx_b = 8'h00, idx_c = 8'h00;
	logic [15:0] addr = 16'hFE20;
	logic [3:0] n_cfg = 4'h0, m_cfg = 4'h0, read_waits, write_waits;
	logic ext_area, busy, done, illegal, cy, hc, zf;
	logic [7:0] result;
	logic [15:0] mem_word, ax, bc, de, hl, eff_addr, store_word;
	logic [5:0] cycles_used;
	integer num_errors = 0, checks = 0, took;
	always #5 clk = ~clk;
	wma_mem_model i_wma_mem_model(.addr(addr), .n_cfg(n_cfg), .m_cfg(m_cfg),
		.ext_area(ext_area), .read_waits(read_waits), .write_waits(write_waits),
		.mem_word(mem_word));
	wma_core i_wma_core(.clk(clk), .rst_n(rst_n), .start(start), .op(op), .amode(amode),
		.rp_sel(rp_sel), .operand(operand), .dest_in(dest_in), .dest_is_acc(dest_is_acc),
		.mem_word(mem_word), .saddr(addr), .disp(disp), .idx_b(idx_b), .idx_c(idx_c),
		.ext_area(ext_area), .read_waits(read_waits), .write_waits(write_waits),
		.busy(busy), .done(done), .illegal(illegal), .result(result),
		.word_accumulator(ax), .general_pair_one(bc), .general_pair_two(de),
		.pointer_pair(hl), .eff_addr(eff_addr), .store_word(store_word),
		.carry_flag(cy), .half_carry_flag(hc), .zero_flag(zf), .cycles_used(cycles_used));
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// one instruction; took is the cycle of done, 60 when it never came
	task go(input wma_op_t o, input wma_amode_t a, input logic [7:0] s, input logic [7:0] d);
		@(negedge clk);
		op = o;
		amode = a;
		operand = s;
		dest_in = d;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		took = 1;
		chk("busy", {15'h0000, busy}, 16'h0001);
		while (done !== 1'b1 && took < 60) begin
			@(negedge clk);
			took++;
		end
		if (took < 60) begin
			chk("cycles_used", {10'h000, cycles_used}, took[15:0]);
			chk("busy end", {15'h0000, busy}, 16'h0000);
		end else begin
			// no done is only allowed for a refused instruction
			chk("refused", {15'h0000, illegal}, 16'h0001);
		end
	endtask
	task flags(input logic [7:0] r, input logic z, input logic h, input logic c);
		chk("result", {8'h00, result}, {8'h00, r});
		chk("zero", zf, z);
		chk("half", hc, h);
		chk("carry", cy, c);
	endtask
	task t_add;
		go(WMA_OP_ADD, WMA_AM_IMM, 8'h01, 8'h0F);
		chk("add imm", took, 16'h0004);
		flags(8'h10, 1'b0, 1'b1, 1'b0);
		go(WMA_OP_ADD, WMA_AM_IMM, 8'h01, 8'hFF);
		flags(8'h00, 1'b1, 1'b1, 1'b1);
		go(WMA_OP_ADD_WITH_CARRY_OP, WMA_AM_IMM, 8'h00, 8'hFF);
		flags(8'h00, 1'b1, 1'b1, 1'b1);
		go(WMA_OP_AND, WMA_AM_IMM, 8'h0F, 8'hF1);
		flags(8'h01, 1'b0, 1'b1, 1'b1);
	endtask
	task t_sub;
		go(WMA_OP_SUB, WMA_AM_IMM, 8'h01, 8'h10);
		flags(8'h0F, 1'b0, 1'b1, 1'b0);
		go(WMA_OP_SUB, WMA_AM_IMM, 8'h01, 8'h00);
		flags(8'hFF, 1'b0, 1'b1, 1'b1);
		go(WMA_OP_SUBTRACT_WITH_BORROW_OP, WMA_AM_IMM, 8'h01, 8'h05);
		flags(8'h03, 1'b0, 1'b0, 1'b0);
	endtask
	task t_timing;
		addr = 16'hFF00;
		go(WMA_OP_ADD, WMA_AM_SADDR, 8'h01, 8'h01);
		chk("saddr slow", took, 16'h0005);
		addr = 16'hFE20;
		go(WMA_OP_ADD, WMA_AM_SADDR, 8'h01, 8'h01);
		chk("saddr fast", took, 16'h0004);
		dest_is_acc = 1'b0;
		go(WMA_OP_ADD, WMA_AM_SADDR, 8'h01, 8'h01);
		chk("saddr imm", took, 16'h0006);
		addr = 16'hFF00;
		go(WMA_OP_ADD, WMA_AM_SADDR, 8'h01, 8'h01);
		chk("saddr imm slow", took, 16'h0008);
		dest_is_acc = 1'b1;
		addr = 16'h8000;
		n_cfg = 4'h3;
		go(WMA_OP_ADD, WMA_AM_ABS, 8'h01, 8'h01);
		chk("abs waits", took, 16'h000C);
	endtask
	task t_word;
		n_cfg = 4'h2;
		m_cfg = 4'h3;
		go(WMA_OP_WORD_MOVE_OP_AX_MEM, WMA_AM_ABS, 8'h00, 8'h00);
		chk("load len", took, 16'h0010);
		chk("load ax", ax, 16'hA5DA);
		go(WMA_OP_WORD_MOVE_OP_MEM_AX, WMA_AM_ABS, 8'h00, 8'h00);
		chk("store len", took, 16'h0012);
		chk("store word", store_word, 16'hA5DA);
		addr = 16'hFE20;
		go(WMA_OP_WORD_MOVE_OP_AX_MEM, WMA_AM_SADDR, 8'h00, 8'h00);
		chk("load fast", ax, 16'h85A4);
	endtask
	task t_pair;
		rp_sel = WMA_RP_HL;
		go(WMA_OP_WORD_MOVE_OP_RP_AX, WMA_AM_REG, 8'h00, 8'h00);
		chk("move len", took, 16'h0004);
		chk("move hl", hl, 16'h85A4);
		rp_sel = WMA_RP_AX;
		go(WMA_OP_WORD_MOVE_OP_RP_AX, WMA_AM_REG, 8'h00, 8'h00);
		chk("ax partner", illegal, 1'b1);
		rp_sel = WMA_RP_BC;
		go(WMA_OP_WORD_SWAP_OP, WMA_AM_REG, 8'h00, 8'h00);
		chk("swap ax", ax, 16'h0000);
		chk("swap bc", bc, 16'h85A4);
		go(WMA_OP_WORD_MOVE_OP_AX_RP, WMA_AM_REG, 8'h00, 8'h00);
		chk("load len", took, 16'h0004);
		chk("load from bc", ax, 16'h85A4);
		rp_sel = WMA_RP_DE;
		go(WMA_OP_WORD_MOVE_OP_RP_AX, WMA_AM_REG, 8'h00, 8'h00);
		chk("move de", de, 16'h85A4);
	endtask
	task t_idx;
		idx_b = 8'h05;
		addr = 16'h85A9;
		n_cfg = 4'h1;
		go(WMA_OP_ADD, WMA_AM_HL_B, 8'h01, 8'h01);
		chk("index addr", eff_addr, 16'h85A9);
		chk("index len", took, 16'h000A);
		disp = 8'h10;
		addr = 16'h85B4;
		go(WMA_OP_SUB, WMA_AM_HL_BYTE, 8'h01, 8'h01);
		chk("disp addr", eff_addr, 16'h85B4);
		chk("disp len", took, 16'h000A);
		idx_c = 8'h02;
		addr = 16'h85A6;
		go(WMA_OP_AND, WMA_AM_HL_C, 8'h01, 8'h01);
		chk("c index addr", eff_addr, 16'h85A6);
		chk("c index len", took, 16'h000A);
		addr = 16'h85A4;
		go(WMA_OP_ADD, WMA_AM_HL, 8'h01, 8'h01);
		chk("pointer len", took, 16'h0006);
	endtask
	// reset in mid-instruction, then one clean instruction
	task t_reset;
		@(negedge clk);
		op = WMA_OP_ADD;
		amode = WMA_AM_IMM;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		rst_n = 1'b0;
		@(negedge clk);
		chk("reset busy", {15'h0000, busy}, 16'h0000);
		chk("reset illegal", {15'h0000, illegal}, 16'h0000);
		chk("reset ax", ax, WMA_RESET_WORD);
		chk("reset count", {10'h000, cycles_used}, 16'h0000);
		rst_n = 1'b1;
		go(WMA_OP_ADD, WMA_AM_IMM, 8'h01, 8'h0F);
		chk("after reset", took, 16'h0004);
		flags(8'h10, 1'b0, 1'b1, 1'b0);
	endtask
	task t_window;
		addr = 16'hFF20;
		go(WMA_OP_ADD, WMA_AM_SADDR, 8'h01, 8'h01);
		chk("out of window", illegal, 1'b1);
		addr = 16'hFE21;
		go(WMA_OP_WORD_MOVE_OP_AX_MEM, WMA_AM_SADDR, 8'h00, 8'h00);
		chk("odd pair", illegal, 1'b1);
	endtask
	task complete_run;
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#50000;
		num_errors++;
		complete_run;
	end
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		t_add;
		t_sub;
		t_timing;
		t_word;
		t_pair;
		t_idx;
		t_window;
		t_reset;
		complete_run;
	end
endmodule
